/* File: bench/bit_processor_sva.sv */
/*
 * Port checker of the bit processor, bound to every instance.
 * Assumes the clock enable is held high while checked.
 */
`timescale 1ns/10ps
module bit_processor_sva
	import bitproc_pkg::*;
(
	// Clock and reset
	input wire logic       i_ref_clk,
	input wire logic       i_rst_b,
	// Register port and bit op
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_op_valid,
	input wire logic       o_op_done,
	// Events and pins
	input arith_flags_type i_arith,
	input wire logic       i_tx_byte_sent,
	input wire logic       i_rx_byte_got,
	input wire logic       i_xmem_rd,
	input wire logic       i_xmem_wr,
	input wire logic       i_ser_doe,
	input wire logic [7:0] o_port3,
	input wire logic       o_p3_rx_oe,
	input wire logic [1:0] o_bank_base
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	wire quiet = !i_arith.upd && !i_op_valid && !i_wr;
	wire psw_rd = quiet && i_rd && i_addr == ADDR_STATUS_WORD;
	wire serial_port_control_rd = !i_wr && i_rd && i_addr == ADDR_SERIAL_CTRL;

	property p_op_done;
		o_op_done == $past(i_op_valid);
	endproperty
	a_op_done: assert property (p_op_done) else $error("op done late");
	property p_unmapped;
		i_rd && i_addr inside {8'h30, 8'h90} |=> o_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_rd_strobe;
		i_xmem_rd |=> !o_port3[P3_RD_STROBE];
	endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe");
	property p_wr_strobe;
		i_xmem_wr |=> !o_port3[P3_WR_STROBE];
	endproperty
	a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe");
	property p_bank;
		i_wr && i_addr == ADDR_STATUS_WORD && !i_op_valid |=> ##1
			{3'b000, o_bank_base, 3'b000} == ($past(i_wdata, 2) & 8'h18);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select");
	property p_arith;
		(i_arith.upd && !i_op_valid && !i_wr) ##1 quiet ##1 psw_rd |=>
			{1'b1, o_rdata[PSW_CARRY], o_rdata[PSW_HALF_CARRY], o_rdata[PSW_EXCESS]}
			== $past(i_arith, 3);
	endproperty
	a_arith: assert property (p_arith) else $error("arith flags");
	property p_user;
		(i_wr && i_addr == ADDR_STATUS_WORD && !i_op_valid) ##1 quiet ##1 psw_rd |=>
			(o_rdata & 8'h3a) == ($past(i_wdata, 3) & 8'h38);
	endproperty
	a_user: assert property (p_user) else $error("user flag");
	property p_tx;
		i_tx_byte_sent ##1 !i_wr ##1 serial_port_control_rd |=> o_rdata[SERIAL_PORT_CONTROL_TX_DONE];
	endproperty
	a_tx: assert property (p_tx) else $error("tx done");
	property p_rx;
		i_rx_byte_got ##1 !i_wr ##1 serial_port_control_rd |=> o_rdata[SERIAL_PORT_CONTROL_RX_DONE];
	endproperty
	a_rx: assert property (p_rx) else $error("rx done");
	property p_oe;
		o_p3_rx_oe |-> $past(i_ser_doe);
	endproperty
	a_oe: assert property (p_oe) else $error("data enable");
endmodule // bit_processor_sva

bind bit_processor bit_processor_sva u_sva (
	.i_ref_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_op_valid,
	.o_op_done, .i_arith, .i_tx_byte_sent, .i_rx_byte_got, .i_xmem_rd, .i_xmem_wr,
	.i_ser_doe, .o_port3, .o_p3_rx_oe, .o_bank_base
);

/* File: bench/bit_processor_test.sv */
/*
 * Self-checking bench of the bit processor: register port, bit ops, events.
 * Assumes the checker is bound to the design from its own file.
 */
`timescale 1ns/10ps
module bit_processor_test
	import bitproc_pkg::*;
();
	// ====================
	// Signals
	logic            i_ref_clk, i_rst_b, i_clk_en, i_wr, i_rd, i_op_valid;
	logic            i_ser_clk, i_ser_txd, i_ser_dout, i_ser_doe;
	// Event pulses, one bit each
	localparam int   EV_SRV0 = 0, EV_SRV1 = 1, EV_TX = 2, EV_RX = 3, EV_XRD = 4, EV_XWR = 5;
	logic [5:0]      ev_r;
	wire             i_ext0_serviced, i_ext1_serviced, i_tx_byte_sent, i_rx_byte_got;
	wire             i_xmem_rd, i_xmem_wr;
	assign {i_xmem_wr, i_xmem_rd, i_rx_byte_got, i_tx_byte_sent} = ev_r[5:2];
	assign {i_ext1_serviced, i_ext0_serviced} = ev_r[1:0];
	logic            i_ext_irq0_pin, i_ext_irq1_pin, i_p3_rx_pin;
	logic            o_op_result, o_op_done, o_p3_rx_oe, o_ext0_req, o_ext1_req;
	logic [7:0]      i_addr, i_wdata, i_op_bit_addr, o_rdata, o_port3, rd_v;
	logic [3:0]      i_op_code;
	logic [1:0]      o_bank_base, o_serial_mode;
	arith_flags_type i_arith;
	int              error_cnt, compares;
	// Op, bit address, carry afterwards
	localparam logic [12:0] CTAB [12] = '{
		{OP_SET_C, 8'h00, 1'b1}, {OP_CLR_C, 8'h00, 1'b0}, {OP_CPL_C, 8'h00, 1'b1},
		{OP_MOV_BIT_C, 8'h10, 1'b1}, {OP_CLR_C, 8'h00, 1'b0}, {OP_ORL_C, 8'h10, 1'b1},
		{OP_ANL_C_N, 8'h10, 1'b0}, {OP_ORL_C_N, 8'h11, 1'b1}, {OP_ANL_C, 8'h11, 1'b0},
		{OP_MOV_C_BIT, 8'h10, 1'b1}, {OP_CLR_BIT, 8'hd7, 1'b0}, {OP_CPL_BIT, 8'hd7, 1'b1}
	};

	bit_processor #(.RAM_BYTES(RAM_BIT_BYTES)) uut (
		.i_ref_clk, .i_rst_b, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_op_valid, .i_op_code, .i_op_bit_addr, .o_op_result, .o_op_done, .i_arith,
		.i_ext0_serviced, .i_ext1_serviced, .i_tx_byte_sent, .i_rx_byte_got,
		.i_xmem_rd, .i_xmem_wr, .i_ser_clk, .i_ser_txd, .i_ser_dout, .i_ser_doe,
		.i_ext_irq0_pin, .i_ext_irq1_pin, .i_p3_rx_pin, .o_port3, .o_p3_rx_oe,
		.o_bank_base, .o_ext0_req, .o_ext1_req, .o_serial_mode
	);

	// ====================
	// Tasks
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rdc(string n, logic [7:0] a, logic [7:0] m, logic [7:0] e);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(n, o_rdata & m, e);
	endtask
	task automatic op(logic [3:0] c, logic [7:0] a);
		@(posedge i_ref_clk);
		i_op_valid <= 1'b1;
		i_op_code <= c;
		i_op_bit_addr <= a;
		@(posedge i_ref_clk);
		i_op_valid <= 1'b0;
		#1;
		chk("op_done", o_op_done, 8'h01);
	endtask
	task automatic pulse(int k);
		@(posedge i_ref_clk);
		ev_r <= 6'(1 << k);
		@(posedge i_ref_clk);
		ev_r <= '0;
	endtask
	task automatic arith(logic [3:0] v);
		@(posedge i_ref_clk);
		i_arith <= v;
		@(posedge i_ref_clk);
		i_arith <= 4'h0;
	endtask

	// ====================
	// Scenarios
	task automatic t_ram();
		op(OP_SET_BIT, 8'h00);
		op(OP_SET_BIT, 8'h7f);
		op(OP_SET_BIT, 8'h0b);
		rdc("ram20", 8'h20, 8'hff, 8'h01);
		rdc("ram2f", 8'h2f, 8'hff, 8'h80);
		rdc("ram21", 8'h21, 8'hff, 8'h08);
		wr(8'h25, 8'h5a);
		op(OP_CLR_BIT, 8'h29);
		op(OP_CPL_BIT, 8'h2f);
		rdc("ram25", 8'h25, 8'hff, 8'hd8);
	endtask
	task automatic t_psw();
		op(OP_SET_BIT, 8'hd5);
		rdc("user", ADDR_STATUS_WORD, 8'hff, 8'h20);
		for (int b = 0; b < 4; b++) begin
			wr(ADDR_STATUS_WORD, 8'(b << 3) | 8'h03);
			cyc(1);
			chk("bank", {6'h00, o_bank_base}, 8'(b));
			rdc("psw", ADDR_STATUS_WORD, 8'hff, 8'(b << 3));
		end
		wr(ADDR_ACCUM, 8'h07);
		rdc("parity", ADDR_STATUS_WORD, 8'h01, 8'h01);
		wr(ADDR_ACCUM, 8'h00);
		rdc("parity0", ADDR_STATUS_WORD, 8'h01, 8'h00);
	endtask
	task automatic t_carry();
		for (int i = 0; i < 12; i++) begin
			op(CTAB[i][12:9], CTAB[i][8:1]);
			op(OP_NONE, 8'h00);
			chk("carry", o_op_result, CTAB[i][0]);
		end
		rdc("carry_psw", ADDR_STATUS_WORD, 8'h80, 8'h80);
		rdc("ram22", 8'h22, 8'hff, 8'h01);
		op(OP_TEST_BIT, 8'h10);
		chk("test", o_op_result, 8'h01);
		op(OP_TEST_CLR, 8'h10);
		chk("test_clr", o_op_result, 8'h01);
		op(OP_TEST_BIT, 8'h10);
		chk("cleared", o_op_result, 8'h00);
	endtask
	task automatic t_arith();
		wr(ADDR_STATUS_WORD, 8'h00);
		arith(4'hf);
		rdc("arith", ADDR_STATUS_WORD, 8'hff, 8'hc4);
		arith(4'h8);
		rdc("arith0", ADDR_STATUS_WORD, 8'hff, 8'h00);
		wr(ADDR_STATUS_WORD, 8'h80);
		rdc("sw_carry", ADDR_STATUS_WORD, 8'hff, 8'h80);
	endtask
	task automatic t_ext();
		wr(ADDR_TIMER_IRQ_CTRL, 8'h01);
		@(posedge i_ref_clk);
		i_ext_irq0_pin <= 1'b0;
		cyc(3);
		chk("req0", o_ext0_req, 8'h01);
		rdc("edge", ADDR_TIMER_IRQ_CTRL, 8'h0f, 8'h03);
		pulse(EV_SRV0);
		rdc("edge_held", ADDR_TIMER_IRQ_CTRL, 8'h0f, 8'h01);
		@(posedge i_ref_clk);
		i_ext_irq0_pin <= 1'b1;
		i_ext_irq1_pin <= 1'b0;
		cyc(3);
		chk("req1", o_ext1_req, 8'h01);
		pulse(EV_SRV1);
		rdc("level", ADDR_TIMER_IRQ_CTRL, 8'h0f, 8'h09);
		@(posedge i_ref_clk);
		i_ext_irq1_pin <= 1'b1;
		pulse(EV_SRV1);
		rdc("served", ADDR_TIMER_IRQ_CTRL, 8'h0f, 8'h01);
		chk("reqs", {o_ext0_req, o_ext1_req}, 8'h00);
	endtask
	task automatic t_ser();
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_SERIAL_CTRL, 8'(m << 6));
			cyc(1);
			chk("mode", {6'h00, o_serial_mode}, 8'(m));
		end
		@(posedge i_ref_clk);
		i_ser_txd <= 1'b0;
		i_ser_clk <= 1'b1;
		i_ser_doe <= 1'b1;
		cyc(2);
		chk("uart", {o_port3[1:0], o_p3_rx_oe}, 8'h02);
		wr(ADDR_SERIAL_CTRL, 8'h00);
		@(posedge i_ref_clk);
		i_ser_txd <= 1'b1;
		i_ser_clk <= 1'b0;
		cyc(2);
		chk("shift", {o_port3[1:0], o_p3_rx_oe}, 8'h01);
		@(posedge i_ref_clk);
		i_ser_doe <= 1'b0;
		pulse(EV_TX);
		rdc("tx", ADDR_SERIAL_CTRL, 8'h03, 8'h02);
		rdc("tx_held", ADDR_SERIAL_CTRL, 8'h03, 8'h02);
		wr(ADDR_SERIAL_CTRL, 8'h00);
		rdc("tx_clr", ADDR_SERIAL_CTRL, 8'h03, 8'h00);
		pulse(EV_RX);
		rdc("rx", ADDR_SERIAL_CTRL, 8'h03, 8'h01);
		wr(ADDR_SERIAL_CTRL, 8'h00);
		rdc("rx_clr", ADDR_SERIAL_CTRL, 8'h03, 8'h00);
	endtask
	task automatic t_misc();
		pulse(EV_XRD);
		#1;
		chk("rd_low", o_port3[7:6], 8'h01);
		pulse(EV_XWR);
		#1;
		chk("wr_low", o_port3[7:6], 8'h02);
		cyc(1);
		chk("idle", o_port3[7:6], 8'h03);
		// Unmapped, never reserved, enable or priority addresses
		wr(8'h30, 8'hff);
		op(OP_SET_BIT, 8'h93);
		rdc("unmap_30", 8'h30, 8'hff, 8'h00);
		rdc("unmap_90", 8'h90, 8'hff, 8'h00);
		@(posedge i_ref_clk);
		i_p3_rx_pin <= 1'b0;
		rdc("rx_pin", ADDR_PORT3, 8'hff, 8'hfe);
	endtask

	// ====================
	// Main
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		error_cnt++;
		$display("mismatch watchdog expected done seen hang");
		summarize();
	end
	initial begin
		{i_rst_b, i_wr, i_rd, i_op_valid, i_ser_clk} = '0;
		ev_r = '0;
		{i_ser_txd, i_ser_dout, i_ser_doe} = '0;
		{i_clk_en, i_ext_irq0_pin, i_ext_irq1_pin, i_p3_rx_pin} = '1;
		{i_addr, i_wdata, i_op_bit_addr, i_op_code} = '0;
		i_arith = '0;
		error_cnt = 0;
		compares = 0;
		repeat (10) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		t_ram();
		t_psw();
		t_carry();
		t_arith();
		t_ext();
		t_ser();
		t_misc();
		summarize();
	end
endmodule // bit_processor_test

/* File: src/bit_addr_decode.sv */
/*
 * Decoder of a direct bit-address byte into byte address and bit position.
 * Purely combinational; assumes the caller registers the result.
 */
`timescale 1ns/10ps
module bit_addr_decode
	import bitproc_pkg::*;
(
	// Bit address
	input  wire logic [7:0]     i_bit_addr,
	// Decoded target
	output bit_target_type      o_target
);

	wire logic       is_reg_w   = i_bit_addr[7];
	wire logic [7:0] ram_byte_w = ADDR_RAM_BIT_BASE + {4'h0, i_bit_addr[6:3]};
	wire logic [7:0] reg_byte_w = {i_bit_addr[7:3], 3'b000};

	assign o_target.is_reg    = is_reg_w;
	assign o_target.byte_addr = is_reg_w ? reg_byte_w : ram_byte_w;
	assign o_target.bit_pos   = i_bit_addr[2:0];

endmodule // bit_addr_decode

/* File: src/bit_processor.sv */
/*
 * One-bit processor: bit-addressable RAM flags, status word, timer and
 * interrupt control, serial control, port 3 alternate functions, and a
 * carry used as a one-bit accumulator for bit operations.
 * Assumes one 10 MHz clock, synchronous pin inputs and a strobe port.
 */
//
// Contract
// - Carry-only operations take opcode alone or opcode plus displacement.
// - General bit operations take a bit-address byte after the opcode.
// - Top address bit picks group; low half maps RAM bytes from 20H.
// - High half: upper five bits are register address, low three bit.
// - Carry is the one-bit accumulator for two-operand bit operations.
// - Port pins and control bits are each individually bit-addressable.
// - Status word bit 7 is carry, written by hardware and software.
// - Half-carry at status bit 6 tracks carry out of bit 3.
// - Status bit 5 is a software-only user flag.
// - Two bank-select bits choose one of four eight-register banks.
// - Overflow at status bit 2 set by hardware arithmetic.
// - Status bit 0 recomputed each cycle for even parity with accumulator.
// - External edge flags set on edge, cleared when serviced.
// - Trigger type bit: one falling edge, zero low level.
// - Two serial mode bits select shift, 8-bit or two 9-bit UART modes.
// - Transmit-done set by hardware, cleared only by software.
// - Receive-done set by hardware, cleared by software.
// - Port 3 bits 7 and 6 pulse low on external reads and writes.
// - Port 3 bits 1 and 0 carry serial signals per mode.
`timescale 1ns/10ps
module bit_processor
	import bitproc_pkg::*;
#(
	parameter int RAM_BYTES = RAM_BIT_BYTES
)(
	// Clock, reset, enable
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_clk_en,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Bit operation request
	input  wire logic        i_op_valid,
	input  wire logic [3:0]  i_op_code,
	input  wire logic [7:0]  i_op_bit_addr,
	output logic             o_op_result,
	output logic             o_op_done,
	// Core events
	input  arith_flags_type  i_arith,
	input  wire logic        i_ext0_serviced,
	input  wire logic        i_ext1_serviced,
	input  wire logic        i_tx_byte_sent,
	input  wire logic        i_rx_byte_got,
	input  wire logic        i_xmem_rd,
	input  wire logic        i_xmem_wr,
	input  wire logic        i_ser_clk,
	input  wire logic        i_ser_txd,
	input  wire logic        i_ser_dout,
	input  wire logic        i_ser_doe,
	// Pins
	input  wire logic        i_ext_irq0_pin,
	input  wire logic        i_ext_irq1_pin,
	input  wire logic        i_p3_rx_pin,
	output logic      [7:0]  o_port3,
	output logic             o_p3_rx_oe,
	output logic      [1:0]  o_bank_base,
	output logic             o_ext0_req,
	output logic             o_ext1_req,
	output logic      [1:0]  o_serial_mode
);

	if (RAM_BYTES != RAM_BIT_BYTES) begin : g_ram_check
		$error("RAM_BYTES must be 16");
	end

	// ==========================================================
	// State
	logic [7:0] psw_r, timer_irq_control_r, serial_port_control_r, p3_r, acc_r;
	logic [7:0] ram_r [RAM_BYTES];
	logic       irq0_d_r, irq1_d_r;

	// ==========================================================
	// Bit address decode and operand fetch
	bit_target_type tgt_w;

	bit_addr_decode u_dec (
		.i_bit_addr (i_op_bit_addr),
		.o_target   (tgt_w)
	);

	wire logic [3:0] ram_idx_w = 4'(tgt_w.byte_addr - ADDR_RAM_BIT_BASE);
	wire logic       hit_psw_w  = tgt_w.is_reg && tgt_w.byte_addr == ADDR_STATUS_WORD;
	wire logic       hit_timer_irq_control_w = tgt_w.is_reg && tgt_w.byte_addr == ADDR_TIMER_IRQ_CTRL;
	wire logic       hit_serial_port_control_w = tgt_w.is_reg && tgt_w.byte_addr == ADDR_SERIAL_CTRL;
	wire logic       hit_p3_w   = tgt_w.is_reg && tgt_w.byte_addr == ADDR_PORT3;
	wire logic       hit_acc_w  = tgt_w.is_reg && tgt_w.byte_addr == ADDR_ACCUM;
	wire logic       hit_ram_w  = !tgt_w.is_reg;

	wire logic [7:0] src_byte_w =
		hit_ram_w  ? ram_r[ram_idx_w] :
		hit_psw_w  ? psw_r :
		hit_timer_irq_control_w ? timer_irq_control_r :
		hit_serial_port_control_w ? serial_port_control_r :
		hit_p3_w   ? {p3_r[7:1], i_p3_rx_pin} :
		hit_acc_w  ? acc_r : 8'h00;
	wire logic       src_bit_w = src_byte_w[tgt_w.bit_pos];
	wire logic       carry_w   = psw_r[PSW_CARRY];

	// ==========================================================
	// Operation result
	bit_op_type op_w;
	assign op_w = bit_op_type'(i_op_code);
	wire logic op_go_w = i_op_valid && i_clk_en;

	logic carry_nxt, bit_nxt, bit_wr, res_nxt;
	always_comb begin
		carry_nxt = carry_w;
		bit_nxt   = src_bit_w;
		bit_wr    = 1'b0;
		res_nxt   = 1'b0;
		case (op_w)
			OP_SET_C:     carry_nxt = 1'b1;
			OP_CLR_C:     carry_nxt = 1'b0;
			OP_CPL_C:     carry_nxt = !carry_w;
			OP_SET_BIT:   begin bit_nxt = 1'b1; bit_wr = 1'b1; end
			OP_CLR_BIT:   begin bit_nxt = 1'b0; bit_wr = 1'b1; end
			OP_CPL_BIT:   begin bit_nxt = !src_bit_w; bit_wr = 1'b1; end
			OP_MOV_C_BIT: carry_nxt = src_bit_w;
			OP_MOV_BIT_C: begin bit_nxt = carry_w; bit_wr = 1'b1; end
			OP_ANL_C:     carry_nxt = carry_w & src_bit_w;
			OP_ANL_C_N:   carry_nxt = carry_w & !src_bit_w;
			OP_ORL_C:     carry_nxt = carry_w | src_bit_w;
			OP_ORL_C_N:   carry_nxt = carry_w | !src_bit_w;
			OP_TEST_BIT:  res_nxt = src_bit_w;
			OP_TEST_CLR:  begin res_nxt = src_bit_w; bit_nxt = 1'b0; bit_wr = src_bit_w; end
			default:      res_nxt = carry_w;
		endcase
	end

	wire logic bw_w = op_go_w && bit_wr;

	// Byte with only the addressed bit replaced
	function automatic logic [7:0] merge_bit(input logic [7:0] b, input logic [2:0] p,
		input logic v);
		logic [7:0] r;
		r    = b;
		r[p] = v;
		return r;
	endfunction

	wire logic [7:0] merged_w = merge_bit(src_byte_w, tgt_w.bit_pos, bit_nxt);

	// ==========================================================
	// Register port decode
	wire logic sw_psw_w  = i_wr && i_addr == ADDR_STATUS_WORD;
	wire logic sw_timer_irq_control_w = i_wr && i_addr == ADDR_TIMER_IRQ_CTRL;
	wire logic sw_serial_port_control_w = i_wr && i_addr == ADDR_SERIAL_CTRL;
	wire logic sw_p3_w   = i_wr && i_addr == ADDR_PORT3;
	wire logic sw_acc_w  = i_wr && i_addr == ADDR_ACCUM;
	wire logic [7:0] ram_sw_off_w = i_addr - ADDR_RAM_BIT_BASE;
	wire logic sw_ram_w  = i_wr && i_addr >= ADDR_RAM_BIT_BASE && ram_sw_off_w < 8'(RAM_BYTES);

	// Software or bit-op write data per register; bit op wins same cycle
	wire logic [7:0] psw_base_w  = (bw_w && hit_psw_w)  ? merged_w :
		sw_psw_w  ? i_wdata : psw_r;
	wire logic [7:0] timer_irq_control_base_w = (bw_w && hit_timer_irq_control_w) ? merged_w :
		sw_timer_irq_control_w ? i_wdata : timer_irq_control_r;
	wire logic [7:0] serial_port_control_base_w = (bw_w && hit_serial_port_control_w) ? merged_w :
		sw_serial_port_control_w ? i_wdata : serial_port_control_r;

	// ==========================================================
	// Status word
	wire logic [7:0] acc_nxt = (bw_w && hit_acc_w) ? merged_w : sw_acc_w ? i_wdata : acc_r;
	logic [7:0] psw_nxt;
	always_comb begin
		psw_nxt = psw_base_w;
		if (op_go_w)
			psw_nxt[PSW_CARRY] = (bw_w && hit_psw_w) ? merged_w[PSW_CARRY] : carry_nxt;
		if (i_arith.upd) begin
			psw_nxt[PSW_CARRY]      = i_arith.carry;
			psw_nxt[PSW_HALF_CARRY] = i_arith.half_carry;
			psw_nxt[PSW_EXCESS]     = i_arith.excess;
		end
		psw_nxt[1]          = 1'b0;
		psw_nxt[PSW_PARITY] = ^acc_nxt;
	end

	// ==========================================================
	// Timer and interrupt control: edge flags
	wire logic fall0_w = irq0_d_r && !i_ext_irq0_pin;
	wire logic fall1_w = irq1_d_r && !i_ext_irq1_pin;
	logic [7:0] timer_irq_control_nxt;
	always_comb begin
		timer_irq_control_nxt = timer_irq_control_base_w;
		if (i_ext0_serviced)
			timer_irq_control_nxt[TIMER_IRQ_CONTROL_EXT0_EDGE] = 1'b0;
		if (i_ext1_serviced)
			timer_irq_control_nxt[TIMER_IRQ_CONTROL_EXT1_EDGE] = 1'b0;
		if (timer_irq_control_r[TIMER_IRQ_CONTROL_EXT0_TYPE] ? fall0_w : !i_ext_irq0_pin)
			timer_irq_control_nxt[TIMER_IRQ_CONTROL_EXT0_EDGE] = 1'b1;
		if (timer_irq_control_r[TIMER_IRQ_CONTROL_EXT1_TYPE] ? fall1_w : !i_ext_irq1_pin)
			timer_irq_control_nxt[TIMER_IRQ_CONTROL_EXT1_EDGE] = 1'b1;
	end

	// ==========================================================
	// Serial control: done flags set by hardware, set wins over clear
	logic [7:0] serial_port_control_nxt;
	always_comb begin
		serial_port_control_nxt = serial_port_control_base_w;
		if (i_tx_byte_sent)
			serial_port_control_nxt[SERIAL_PORT_CONTROL_TX_DONE] = 1'b1;
		if (i_rx_byte_got)
			serial_port_control_nxt[SERIAL_PORT_CONTROL_RX_DONE] = 1'b1;
	end

	serial_mode_type ser_mode_w;
	assign ser_mode_w = serial_mode_type'({serial_port_control_r[SERIAL_PORT_CONTROL_MODE_HI], serial_port_control_r[SERIAL_PORT_CONTROL_MODE_LO]});
	wire logic shift_mode_w = ser_mode_w == SER_SHIFT;

	// ==========================================================
	// Port 3 latch and pin drive
	wire logic [7:0] p3_nxt = (bw_w && hit_p3_w) ? merged_w : sw_p3_w ? i_wdata : p3_r;
	logic [7:0] pin_nxt;
	always_comb begin
		pin_nxt = p3_r;
		pin_nxt[P3_RD_STROBE] = p3_r[P3_RD_STROBE] & !i_xmem_rd;
		pin_nxt[P3_WR_STROBE] = p3_r[P3_WR_STROBE] & !i_xmem_wr;
		pin_nxt[P3_TX_DATA]   = p3_r[P3_TX_DATA] &
			(shift_mode_w ? i_ser_clk : i_ser_txd);
		pin_nxt[P3_RX_DATA]   = shift_mode_w ? i_ser_dout : 1'b1;
	end

	// ==========================================================
	// Read data
	wire logic [7:0] rd_mux_w =
		(i_addr == ADDR_STATUS_WORD)    ? psw_r :
		(i_addr == ADDR_TIMER_IRQ_CTRL) ? timer_irq_control_r :
		(i_addr == ADDR_SERIAL_CTRL)    ? serial_port_control_r :
		(i_addr == ADDR_PORT3)          ? {p3_r[7:1], i_p3_rx_pin} :
		(i_addr == ADDR_ACCUM)          ? acc_r :
		(i_addr >= ADDR_RAM_BIT_BASE && ram_sw_off_w < 8'(RAM_BYTES)) ?
			ram_r[ram_sw_off_w[3:0]] : 8'h00;

	// ==========================================================
	// Registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			psw_r <= RST_PSW;
		else if (i_clk_en)
			psw_r <= psw_nxt;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			timer_irq_control_r <= RST_TIMER_IRQ_CONTROL;
		else if (i_clk_en)
			timer_irq_control_r <= timer_irq_control_nxt;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			serial_port_control_r <= RST_SERIAL_PORT_CONTROL;
		else if (i_clk_en)
			serial_port_control_r <= serial_port_control_nxt;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			p3_r <= RST_PORT3;
		else if (i_clk_en)
			p3_r <= p3_nxt;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			acc_r <= RST_ACC;
		else if (i_clk_en)
			acc_r <= acc_nxt;
	end

	// Both writers land; a bit op to the same byte wins
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			for (int i = 0; i < RAM_BYTES; i++)
				ram_r[i] <= RST_RAM;
		end else if (i_clk_en) begin
			if (sw_ram_w)
				ram_r[ram_sw_off_w[3:0]] <= i_wdata;
			if (bw_w && hit_ram_w)
				ram_r[ram_idx_w] <= merged_w;
		end
	end

	// Previous pin samples, reset to the idle high level
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			irq0_d_r <= 1'b1;
			irq1_d_r <= 1'b1;
		end else if (i_clk_en) begin
			irq0_d_r <= i_ext_irq0_pin;
			irq1_d_r <= i_ext_irq1_pin;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			o_rdata <= 8'h00;
		else if (i_clk_en)
			o_rdata <= i_rd ? rd_mux_w : 8'h00;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			o_op_result <= 1'b0;
		else if (op_go_w)
			o_op_result <= res_nxt;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b)
			o_op_done <= 1'b0;
		else if (i_clk_en)
			o_op_done <= op_go_w;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_port3    <= RST_PORT3;
			o_p3_rx_oe <= 1'b0;
		end else if (i_clk_en) begin
			o_port3    <= pin_nxt;
			o_p3_rx_oe <= shift_mode_w & i_ser_doe;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_bank_base   <= 2'b00;
			o_ext0_req    <= 1'b0;
			o_ext1_req    <= 1'b0;
			o_serial_mode <= 2'b00;
		end else if (i_clk_en) begin
			o_bank_base   <= {psw_r[PSW_BANK_HI], psw_r[PSW_BANK_LO]};
			o_ext0_req    <= timer_irq_control_r[TIMER_IRQ_CONTROL_EXT0_EDGE];
			o_ext1_req    <= timer_irq_control_r[TIMER_IRQ_CONTROL_EXT1_EDGE];
			o_serial_mode <= ser_mode_w;
		end
	end

endmodule // bit_processor

/* File: src/bitproc_pkg.sv */
/*
 * Package for the one-bit processor and bit-address decoder: register
 * addresses, field positions, reset values, mode encodings, carriers.
 * Assumes a byte-wide register space reached by a plain strobe port.
 */
package bitproc_pkg;

	// ==========================================================
	// Register addresses (byte addresses of the register space)
	localparam logic [7:0] ADDR_RAM_BIT_BASE   = 8'h20;
	localparam logic [7:0] ADDR_PORT3          = 8'hb0;
	localparam logic [7:0] ADDR_TIMER_IRQ_CTRL = 8'h88;
	localparam logic [7:0] ADDR_SERIAL_CTRL    = 8'h98;
	localparam logic [7:0] ADDR_STATUS_WORD    = 8'hd0;
	localparam logic [7:0] ADDR_ACCUM          = 8'he0;
	localparam logic [7:0] ADDR_BIT_OP         = 8'hf0;
	localparam int         RAM_BIT_BYTES       = 16;

	// ==========================================================
	// Field positions
	localparam int PSW_CARRY      = 7;
	localparam int PSW_HALF_CARRY = 6;
	localparam int PSW_USER_FLAG  = 5;
	localparam int PSW_BANK_HI    = 4;
	localparam int PSW_BANK_LO    = 3;
	localparam int PSW_EXCESS     = 2;
	localparam int PSW_PARITY     = 0;
	localparam int TIMER_IRQ_CONTROL_EXT1_EDGE = 3;
	localparam int TIMER_IRQ_CONTROL_EXT1_TYPE = 2;
	localparam int TIMER_IRQ_CONTROL_EXT0_EDGE = 1;
	localparam int TIMER_IRQ_CONTROL_EXT0_TYPE = 0;
	localparam int SERIAL_PORT_CONTROL_MODE_HI   = 7;
	localparam int SERIAL_PORT_CONTROL_MODE_LO   = 6;
	localparam int SERIAL_PORT_CONTROL_TX_DONE   = 1;
	localparam int SERIAL_PORT_CONTROL_RX_DONE   = 0;
	localparam int P3_RD_STROBE   = 7;
	localparam int P3_WR_STROBE   = 6;
	localparam int P3_TX_DATA     = 1;
	localparam int P3_RX_DATA     = 0;
	localparam int BANK_SIZE      = 8;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_PSW   = 8'h00;
	localparam logic [7:0] RST_TIMER_IRQ_CONTROL  = 8'h00;
	localparam logic [7:0] RST_SERIAL_PORT_CONTROL  = 8'h00;
	localparam logic [7:0] RST_PORT3 = 8'hff;
	localparam logic [7:0] RST_ACC   = 8'h00;
	localparam logic [7:0] RST_RAM   = 8'h00;

	// ==========================================================
	// Bit operation codes (i_op_code of the bit operation request, bits 3:0)
	typedef enum logic [3:0] {
		OP_NONE      = 4'h0,
		OP_SET_C     = 4'h1,
		OP_CLR_C     = 4'h2,
		OP_CPL_C     = 4'h3,
		OP_SET_BIT   = 4'h4,
		OP_CLR_BIT   = 4'h5,
		OP_CPL_BIT   = 4'h6,
		OP_MOV_C_BIT = 4'h7,
		OP_MOV_BIT_C = 4'h8,
		OP_ANL_C     = 4'h9,
		OP_ANL_C_N   = 4'ha,
		OP_ORL_C     = 4'hb,
		OP_ORL_C_N   = 4'hc,
		OP_TEST_BIT  = 4'hd,
		OP_TEST_CLR  = 4'he
	} bit_op_type;

	typedef enum logic [1:0] {
		SER_SHIFT    = 2'b00,
		SER_UART8    = 2'b01,
		SER_UART9_FX = 2'b10,
		SER_UART9_VR = 2'b11
	} serial_mode_type;

	// Decoded direct bit address
	typedef struct packed {
		logic       is_reg;
		logic [7:0] byte_addr;
		logic [2:0] bit_pos;
	} bit_target_type;

	// Arithmetic flag update from the core
	typedef struct packed {
		logic upd;
		logic carry;
		logic half_carry;
		logic excess;
	} arith_flags_type;

endpackage
